// ===== rtl/gpio_pkg.sv
package gpio_pkg;

    // port width and placement of the data bits inside the byte
    localparam int          PINS       = 6;
    localparam int          DATA_LSB   = 2;
    localparam int          SPI_LSB    = 2;
    localparam int          SPI_PINS   = 4;
    localparam int          LED_BITS   = 3;
    localparam int          IRQ_BITS   = 2;

    // register byte addresses
    localparam logic [7:0]  ADDR_DATA  = 8'h08;
    localparam logic [7:0]  ADDR_DIR   = 8'h0c;
    localparam logic [7:0]  ADDR_OPT1  = 8'h10;
    localparam logic [7:0]  ADDR_OPT2  = 8'h14;
    localparam logic [7:0]  ADDR_STAT  = 8'h18;
    localparam logic [7:0]  ADDR_MASK  = 8'h1c;

    // port option one: led sink drive bits for port b pins 5, 1, 0
    localparam int          LED_B0     = 0;
    localparam int          LED_B1     = 1;
    localparam int          LED_B5     = 5;

    // port option two fields
    localparam int          OPT2_PULL2 = 0;
    localparam int          OPT2_PULL3 = 1;
    localparam int          OPT2_DPLUS = 2;
    localparam int          OPT2_IRQ3  = 3;
    localparam int          OPT2_BITS  = 4;

    // status and mask fields
    localparam int          STAT_PIN3  = 0;
    localparam int          STAT_EXT   = 1;

    // reset values
    localparam logic [5:0]  RST_DIR    = 6'h00;
    localparam logic [5:0]  RST_LATCH  = 6'h00;
    localparam logic [2:0]  RST_LED    = 3'h0;
    localparam logic [3:0]  RST_OPT2   = 4'h0;
    localparam logic [1:0]  RST_IRQ    = 2'h0;
    localparam logic [7:0]  RST_RDATA  = 8'h00;

    typedef enum logic [1:0] {
        P2_USB  = 2'b00,
        P2_KBD  = 2'b01,
        P2_GPIO = 2'b10
    } pin2_mode_e;

    typedef enum logic [1:0] {
        P3_USB  = 2'b00,
        P3_IRQ  = 2'b01,
        P3_GPIO = 2'b10
    } pin3_mode_e;

    // open-drain pad: enable (low) only while the latch asks for a low
    function automatic logic od_oe_n(input logic dir, input logic latch);
        od_oe_n = ~(dir & ~latch);
    endfunction : od_oe_n

endpackage : gpio_pkg

// ===== rtl/fall_edge_det.sv
`timescale 1ns/1ps
module fall_edge_det (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    // level in, pulse out
    input  wire logic level_i,
    input  wire logic enable_i,
    output logic      fall_o
);

    logic prev_r;

    // idle level of both request lines is high
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            prev_r <= 1'b1;
        end
        else
        begin
            prev_r <= level_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            fall_o <= 1'b0;
        end
        else
        begin
            fall_o <= enable_i & prev_r & ~level_i;
        end
    end

endmodule : fall_edge_det

// ===== rtl/port_e_gpio_pin_mux.sv
// Contract
// R1 - with usb on, pin 2 is d+; d+ pullup follows the d+ pullup enable
// R2 - usb off, clock generator on: pin 2 open-drain clock out, pullup selectable
// R3 - both off: pin 2 open-drain gpio by direction; 1.2k wins over 5k
// R4 - usb on: pins 2 and 3 go to usb; port settings ignored
// R5 - usb off, pin 3 irq on: pin 3 input to interrupt logic, pullup selectable
// R6 - usb off, irq off: pin 3 gpio in or open-drain out, optional 5k
// R7 - 5k pullups on pins 2 and 3 only while usb is off
// R8 - d+ pullup enable overrides pin 2 weak pullup; never both active
// R9 - direction bit 1 enables the output buffer, 0 makes an input
// R10 - reset clears all six direction bits
// R11 - data read gives latch where direction is 1, pin where 0
// R12 - latch always writable; input pins unaffected by the write
// R13 - spi on takes the four upper pins; direction still selects read source
// R14 - software writes the latch before turning a pin to output
// R15 - led bits select high-sink drive for port b pins 5, 1, 0
// R16 - six data latch bits at positions 7 to 2
// R17 - pin 3 edge sets its flag; request ored with dedicated irq pin
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module port_e_gpio_pin_mux
    import gpio_pkg::*;
(
    // clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                resetn_i,
    // register port
    input  wire logic [7:0]          addr_i,
    input  wire logic [7:0]          wr_data_i,
    input  wire logic                wr_en_i,
    input  wire logic                rd_en_i,
    output logic      [7:0]          rd_data_o,
    // pads, index 0 is pin 2
    input  wire logic [PINS-1:0]     pin_in_i,
    output logic      [PINS-1:0]     pin_out_o,
    output logic      [PINS-1:0]     pin_oe_n_o,
    output logic      [1:0]          pull_5k_o,
    output logic                     pull_1k2_o,
    output logic                     pull_dplus_o,
    output logic      [LED_BITS-1:0] led_sink_drive_o,
    // usb hand-over, index 0 is d+
    input  wire logic                usb_function_on_i,
    input  wire logic [1:0]          usb_out_i,
    input  wire logic [1:0]          usb_oe_n_i,
    output logic      [1:0]          usb_in_o,
    // keyboard clock generator
    input  wire logic                kbd_clock_gen_on_i,
    input  wire logic                kbd_clk_low_i,
    output logic                     kbd_clk_in_o,
    // spi hand-over
    input  wire logic                spi_pins_on_i,
    input  wire logic [SPI_PINS-1:0] spi_out_i,
    input  wire logic [SPI_PINS-1:0] spi_oe_n_i,
    output logic      [SPI_PINS-1:0] spi_in_o,
    // external interrupt
    input  wire logic                ext_irq_n_i,
    output logic                     irq_req_o,
    output logic                     irq_o
);

    logic [PINS-1:0]     latch_r;
    logic [PINS-1:0]     dir_r;
    logic [LED_BITS-1:0] led_r;
    logic [OPT2_BITS-1:0] opt2_r;
    logic [IRQ_BITS-1:0] stat_r;
    logic [IRQ_BITS-1:0] stat_nxt;
    logic [IRQ_BITS-1:0] mask_r;
    logic [PINS-1:0]     pin_smp_r;
    logic [PINS-1:0]     pin_out_nxt;
    logic [PINS-1:0]     pin_oe_n_nxt;
    logic [PINS-1:0]     read_view;
    logic [7:0]          rd_data_nxt;
    logic                pin3_fall;
    logic                ext_fall;
    pin2_mode_e          pin2_mode;
    pin3_mode_e          pin3_mode;

    // pin ownership priority
    always_comb
    begin
        if (usb_function_on_i)
            pin2_mode = P2_USB;
        else if (kbd_clock_gen_on_i)
            pin2_mode = P2_KBD;
        else
            pin2_mode = P2_GPIO;
        if (usb_function_on_i)
            pin3_mode = P3_USB;
        else if (opt2_r[OPT2_IRQ3])
            pin3_mode = P3_IRQ;
        else
            pin3_mode = P3_GPIO;
    end

    // register writes
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            latch_r <= RST_LATCH;
        else if (wr_en_i && addr_i == ADDR_DATA)
            latch_r <= wr_data_i[DATA_LSB +: PINS]; // see R12 see R16
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            dir_r <= RST_DIR; // see R10
        else if (wr_en_i && addr_i == ADDR_DIR)
            dir_r <= wr_data_i[DATA_LSB +: PINS];
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            led_r  <= RST_LED;
            opt2_r <= RST_OPT2;
            mask_r <= RST_IRQ;
        end
        else if (wr_en_i)
        begin
            if (addr_i == ADDR_OPT1)
            begin
                led_r <= {wr_data_i[LED_B5], wr_data_i[LED_B1], wr_data_i[LED_B0]};
            end
            if (addr_i == ADDR_OPT2)
            begin
                opt2_r <= wr_data_i[OPT2_BITS-1:0];
            end
            if (addr_i == ADDR_MASK)
            begin
                mask_r <= wr_data_i[IRQ_BITS-1:0];
            end
        end
    end

    // pads are synchronous; one sampling stage feeds reads and edge logic
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            pin_smp_r <= {PINS{1'b1}};
        end
        else
        begin
            pin_smp_r <= pin_in_i;
        end
    end

    fall_edge_det u_pin3_edge (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .level_i   (pin_smp_r[1]),
        .enable_i  (pin3_mode == P3_IRQ),
        .fall_o    (pin3_fall)
    );

    fall_edge_det u_ext_edge (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .level_i   (ext_irq_n_i),
        .enable_i  (1'b1),
        .fall_o    (ext_fall)
    );

    // sticky status, write one to clear; a new edge beats the clear
    always_comb
    begin
        stat_nxt = stat_r;
        if (wr_en_i && addr_i == ADDR_STAT)
        begin
            stat_nxt = stat_r & ~wr_data_i[IRQ_BITS-1:0];
        end
        stat_nxt[STAT_PIN3] = stat_nxt[STAT_PIN3] | pin3_fall; // see R17
        stat_nxt[STAT_EXT]  = stat_nxt[STAT_EXT] | ext_fall;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            stat_r    <= RST_IRQ;
            irq_o     <= 1'b0;
            irq_req_o <= 1'b0;
        end
        else
        begin
            stat_r    <= stat_nxt;
            irq_o     <= |(stat_nxt & mask_r);
            irq_req_o <= pin3_fall | ext_fall; // see R17
        end
    end

    // read path
    assign read_view = (dir_r & latch_r) | (~dir_r & pin_smp_r); // see R11 see R13

    always_comb
    begin
        rd_data_nxt = RST_RDATA;
        unique case (addr_i)
            ADDR_DATA: rd_data_nxt[DATA_LSB +: PINS] = read_view;
            ADDR_DIR:  rd_data_nxt[DATA_LSB +: PINS] = dir_r;
            ADDR_OPT1:
            begin
                rd_data_nxt[LED_B0] = led_r[0]; // see R15
                rd_data_nxt[LED_B1] = led_r[1];
                rd_data_nxt[LED_B5] = led_r[2];
            end
            ADDR_OPT2: rd_data_nxt[OPT2_BITS-1:0] = opt2_r;
            ADDR_STAT: rd_data_nxt[IRQ_BITS-1:0]  = stat_r;
            ADDR_MASK: rd_data_nxt[IRQ_BITS-1:0]  = mask_r;
            default:   rd_data_nxt = RST_RDATA;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i || !rd_en_i)
        begin
            rd_data_o <= RST_RDATA;
        end
        else
        begin
            rd_data_o <= rd_data_nxt;
        end
    end

    // pad drive; upper pins are push-pull, pins 2 and 3 open-drain unless usb drives them
    always_comb
    begin
        pin_out_nxt  = latch_r;
        pin_oe_n_nxt = ~dir_r; // see R9
        unique case (pin2_mode)
            P2_USB:
            begin
                pin_out_nxt[0]  = usb_out_i[0]; // see R4
                pin_oe_n_nxt[0] = usb_oe_n_i[0];
            end
            P2_KBD:
            begin
                pin_out_nxt[0]  = 1'b0; // see R2
                pin_oe_n_nxt[0] = ~kbd_clk_low_i;
            end
            P2_GPIO:
            begin
                pin_out_nxt[0]  = 1'b0; // see R3
                pin_oe_n_nxt[0] = od_oe_n(dir_r[0], latch_r[0]);
            end
        endcase
        unique case (pin3_mode)
            P3_USB:
            begin
                pin_out_nxt[1]  = usb_out_i[1]; // see R4
                pin_oe_n_nxt[1] = usb_oe_n_i[1];
            end
            P3_IRQ:
            begin
                pin_out_nxt[1]  = 1'b0; // see R5
                pin_oe_n_nxt[1] = 1'b1;
            end
            P3_GPIO:
            begin
                pin_out_nxt[1]  = 1'b0; // see R6
                pin_oe_n_nxt[1] = od_oe_n(dir_r[1], latch_r[1]);
            end
        endcase
        // spi owns its pins outright, direction bits only steer reads
        if (spi_pins_on_i)
        begin
            pin_out_nxt[SPI_LSB +: SPI_PINS]  = spi_out_i; // see R13
            pin_oe_n_nxt[SPI_LSB +: SPI_PINS] = spi_oe_n_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            pin_out_o  <= RST_LATCH;
            pin_oe_n_o <= {PINS{1'b1}};
        end
        else
        begin
            pin_out_o  <= pin_out_nxt;
            pin_oe_n_o <= pin_oe_n_nxt;
        end
    end

    // pullups: 1.2k and 5k on pin 2 are mutually exclusive by construction
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            pull_5k_o    <= 2'b00;
            pull_1k2_o   <= 1'b0;
            pull_dplus_o <= 1'b0;
        end
        else
        begin
            pull_dplus_o <= usb_function_on_i & opt2_r[OPT2_DPLUS]; // see R1
            pull_1k2_o   <= ~usb_function_on_i & opt2_r[OPT2_DPLUS]; // see R3 see R8
            pull_5k_o[0] <= ~usb_function_on_i & ~opt2_r[OPT2_DPLUS]
                            & opt2_r[OPT2_PULL2]; // see R7 see R8
            pull_5k_o[1] <= ~usb_function_on_i & opt2_r[OPT2_PULL3]; // see R7
        end
    end

    // hand-over inputs and led drive
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            usb_in_o         <= 2'b11;
            kbd_clk_in_o     <= 1'b1;
            spi_in_o         <= {SPI_PINS{1'b1}};
            led_sink_drive_o <= RST_LED;
        end
        else
        begin
            usb_in_o         <= pin_in_i[1:0];
            kbd_clk_in_o     <= pin_in_i[0];
            spi_in_o         <= pin_in_i[SPI_LSB +: SPI_PINS];
            led_sink_drive_o <= led_r; // see R15
        end
    end

    a_usb_pin_grant: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        usb_function_on_i |=> pin_oe_n_o[1:0] == $past(usb_oe_n_i)) // see R4
        else $error("usb pins not handed over");
    a_dplus_pull_follow: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (usb_function_on_i && opt2_r[OPT2_DPLUS]) |=> pull_dplus_o && !pull_1k2_o) // see R1
        else $error("d+ pullup not applied");
    a_kbd_clock_drive: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (!usb_function_on_i && kbd_clock_gen_on_i)
        |=> !pin_out_o[0] && pin_oe_n_o[0] == !$past(kbd_clk_low_i)) // see R2
        else $error("keyboard clock not driven on pin 2");
    a_pin2_open_drain: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (!usb_function_on_i && !kbd_clock_gen_on_i && dir_r[0] && !latch_r[0])
        |=> !pin_oe_n_o[0] && !pin_out_o[0]) // see R3
        else $error("pin 2 open drain low missing");
    a_pin3_irq_input: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (!usb_function_on_i && opt2_r[OPT2_IRQ3]) |=> pin_oe_n_o[1]) // see R5
        else $error("pin 3 driven while irq input");
    a_weak_pull_usb: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        usb_function_on_i |=> pull_5k_o == 2'b00) // see R7
        else $error("weak pullup on with usb");
    a_pull_exclusive: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !(pull_5k_o[0] && pull_1k2_o)) // see R8
        else $error("both pin 2 pullups active");
    a_dir_reset: assert property (@(posedge sys_clk_i)
        !resetn_i |=> dir_r == RST_DIR) // see R10
        else $error("direction not cleared by reset");
    a_read_mix: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (rd_en_i && addr_i == ADDR_DATA)
        |=> rd_data_o[DATA_LSB +: PINS] == $past(read_view)) // see R11
        else $error("data read source wrong");
    a_spi_override: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        spi_pins_on_i |=> pin_out_o[SPI_LSB +: SPI_PINS] == $past(spi_out_i)) // see R13
        else $error("spi pins not overridden");
    a_pin3_flag_set: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        pin3_fall |=> stat_r[STAT_PIN3] && irq_req_o) // see R17
        else $error("pin 3 edge lost");

endmodule : port_e_gpio_pin_mux

// ===== tb/pad_env.sv
`timescale 1ns/1ps
module pad_env
    import gpio_pkg::*;
(
    // clock
    input  wire logic            sys_clk_i,
    // design side of the pads
    input  wire logic [PINS-1:0] pin_out_i,
    input  wire logic [PINS-1:0] pin_oe_n_i,
    input  wire logic [1:0]      pull_5k_i,
    input  wire logic            pull_1k2_i,
    input  wire logic            pull_dplus_i,
    // outside world
    input  wire logic [PINS-1:0] ext_val_i,
    input  wire logic [PINS-1:0] ext_en_i,
    output logic      [PINS-1:0] pin_o
);
    logic [PINS-1:0] float_r = '0;
    logic [PINS-1:0] pulled;

    // floating pins flip so a stale level never passes for a read
    always @(posedge sys_clk_i)
    begin
        float_r <= ~float_r;
    end

    assign pulled = {4'h0, pull_5k_i[1], pull_5k_i[0] | pull_1k2_i | pull_dplus_i};

    always_comb
    begin
        for (int i = 0; i < PINS; i++)
        begin
            if (!pin_oe_n_i[i])
                pin_o[i] = pin_out_i[i];
            else if (ext_en_i[i])
                pin_o[i] = ext_val_i[i];
            else if (pulled[i])
                pin_o[i] = 1'b1;
            else
                pin_o[i] = float_r[i];
        end
    end
endmodule : pad_env

// ===== tb/port_e_gpio_pin_mux_bench.sv
`timescale 1ns/1ps
module port_e_gpio_pin_mux_bench
    import gpio_pkg::*;
;
    logic                sys_clk_i = 1'b0;
    logic                resetn_i, wr_en_i, rd_en_i, pull_1k2_o, pull_dplus_o;
    logic [7:0]          addr_i, wr_data_i, rd_data_o;
    logic [PINS-1:0]     pin_in_i, pin_out_o, pin_oe_n_o, ext_val, ext_en;
    logic [1:0]          pull_5k_o, usb_out_i, usb_oe_n_i, usb_in_o;
    logic [LED_BITS-1:0] led_sink_drive_o;
    logic                usb_function_on_i, kbd_clock_gen_on_i, kbd_clk_low_i, kbd_clk_in_o;
    logic                spi_pins_on_i, ext_irq_n_i, irq_req_o, irq_o;
    logic [SPI_PINS-1:0] spi_out_i, spi_oe_n_i, spi_in_o;
    int                  err_count, num_checks, cycles, req_count, n;

    port_e_gpio_pin_mux u_dut (.sys_clk_i, .resetn_i, .addr_i, .wr_data_i, .wr_en_i,
        .rd_en_i, .rd_data_o, .pin_in_i, .pin_out_o, .pin_oe_n_o, .pull_5k_o, .pull_1k2_o,
        .pull_dplus_o, .led_sink_drive_o, .usb_function_on_i, .usb_out_i, .usb_oe_n_i,
        .usb_in_o, .kbd_clock_gen_on_i, .kbd_clk_low_i, .kbd_clk_in_o, .spi_pins_on_i,
        .spi_out_i, .spi_oe_n_i, .spi_in_o, .ext_irq_n_i, .irq_req_o, .irq_o);

    pad_env u_pads (.sys_clk_i, .pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o),
        .pull_5k_i(pull_5k_o), .pull_1k2_i(pull_1k2_o), .pull_dplus_i(pull_dplus_o),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_o(pin_in_i));

    always #20 sys_clk_i = ~sys_clk_i;

    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (irq_req_o === 1'b1)
            req_count++;
        if (cycles == 20000)
        begin
            err_count++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_en_i   <= 1'b1;
        @(posedge sys_clk_i);
        wr_en_i   <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        addr_i  <= a;
        rd_en_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_en_i <= 1'b0;
        #1;
        chk(nm, e, rd_data_o);
    endtask : rchk

    task automatic t_reset;
        rchk("dir after reset", ADDR_DIR, 8'h00);
        chk("oe_n after reset", 8'h3f, 8'(pin_oe_n_o));
        rchk("unmapped", 8'h04, 8'h00);
    endtask : t_reset

    task automatic t_port;
        @(posedge sys_clk_i);
        ext_en  <= 6'h3f;
        ext_val <= 6'h15;
        wr(ADDR_DATA, 8'hab);
        tick(3);
        chk("oe_n inputs", 8'h3f, 8'(pin_oe_n_o));
        rchk("data pins", ADDR_DATA, 8'h54);
        wr(ADDR_DIR, 8'hf0);
        tick(3);
        chk("oe_n outputs", 8'h03, 8'(pin_oe_n_o));
        chk("pad out", 8'h0a, 8'(pin_out_o[5:2]));
        rchk("data mixed", ADDR_DATA, 8'ha4);
        rchk("dir read", ADDR_DIR, 8'hf0);
    endtask : t_port

    task automatic t_pin2;
        wr(ADDR_DATA, 8'h00);
        @(posedge sys_clk_i);
        usb_oe_n_i    <= 2'b10;
        usb_out_i     <= 2'b01;
        for (int m = 0; m < 3; m++)
        begin
            for (int p = 0; p < 4; p++)
            begin
                @(posedge sys_clk_i);
                usb_function_on_i  <= (m == 0);
                kbd_clock_gen_on_i <= (m == 1);
                kbd_clk_low_i      <= !p[0];
                wr(ADDR_DIR, (m == 1) ? 8'h00 : 8'h0c);
                wr(ADDR_OPT2, {5'h0, p[1], p[0], p[0]});
                tick(3);
                chk("pull dplus", 8'(m == 0 && p[1]), 8'(pull_dplus_o));
                chk("pull 1k2", 8'(m != 0 && p[1]), 8'(pull_1k2_o));
                chk("pull 5k", {6'h0, m != 0 && p[0], m != 0 && p[0] && !p[1]},
                    8'(pull_5k_o));
                chk("oe_n pins 2 3", {6'h0, m != 2, m == 1 && p[0]},
                    8'(pin_oe_n_o[1:0]));
                if (m == 0)
                begin
                    chk("pad out dplus", 8'h01, 8'(pin_out_o[0]));
                    chk("usb in", 8'h01, 8'(usb_in_o));
                end
                if (m == 1)
                    chk("kbd clk in", 8'(p[0]), 8'(kbd_clk_in_o));
            end
        end
        @(posedge sys_clk_i);
        usb_function_on_i  <= 1'b0;
        kbd_clock_gen_on_i <= 1'b0;
    endtask : t_pin2

    task automatic t_irq;
        @(posedge sys_clk_i);
        ext_en  <= 6'h02;
        ext_val <= 6'h02;
        wr(ADDR_DIR, 8'h08);
        wr(ADDR_OPT2, 8'h0a);
        wr(ADDR_MASK, 8'h01);
        wr(ADDR_STAT, 8'h03);
        tick(3);
        chk("oe_n pin 3 irq", 8'h01, 8'(pin_oe_n_o[1]));
        chk("pull 5k pin 3", 8'h01, 8'(pull_5k_o[1]));
        n = req_count;
        @(posedge sys_clk_i);
        ext_val <= 6'h00;
        tick(5);
        chk("irq pin 3", 8'h01, 8'(irq_o));
        chk("req pulses", 8'(n + 1), 8'(req_count));
        rchk("status pin 3", ADDR_STAT, 8'h01);
        wr(ADDR_STAT, 8'h01);
        tick(2);
        chk("irq cleared", 8'h00, 8'(irq_o));
        n = req_count;
        @(posedge sys_clk_i);
        ext_irq_n_i <= 1'b0;
        tick(5);
        chk("irq masked", 8'h00, 8'(irq_o));
        chk("req pulses ext", 8'(n + 1), 8'(req_count));
        rchk("status ext", ADDR_STAT, 8'h02);
        wr(ADDR_MASK, 8'h02);
        tick(2);
        chk("irq unmasked", 8'h01, 8'(irq_o));
        wr(ADDR_STAT, 8'h02);
        ext_val     <= 6'h02;
        ext_irq_n_i <= 1'b1;
        wr(ADDR_OPT2, 8'h00);
        tick(3);
        @(posedge sys_clk_i);
        ext_val <= 6'h00;
        tick(5);
        rchk("status irq off", ADDR_STAT, 8'h00);
    endtask : t_irq

    task automatic t_spi;
        @(posedge sys_clk_i);
        spi_pins_on_i <= 1'b1;
        spi_oe_n_i    <= 4'h0;
        spi_out_i     <= 4'ha;
        ext_en        <= 6'h03;
        ext_val       <= 6'h00;
        wr(ADDR_DIR, 8'h00);
        tick(3);
        chk("spi oe_n", 8'h00, 8'(pin_oe_n_o[5:2]));
        chk("spi pad out", 8'h0a, 8'(pin_out_o[5:2]));
        chk("spi in", 8'h0a, 8'(spi_in_o));
        rchk("spi read pins", ADDR_DATA, 8'ha0);
        wr(ADDR_DATA, 8'h54);
        wr(ADDR_DIR, 8'hf0);
        tick(3);
        chk("spi pad keeps", 8'h0a, 8'(pin_out_o[5:2]));
        rchk("spi read latch", ADDR_DATA, 8'h50);
        @(posedge sys_clk_i);
        spi_pins_on_i <= 1'b0;
    endtask : t_spi

    task automatic t_led;
        wr(ADDR_OPT1, 8'h23);
        tick(2);
        chk("led all", 8'h07, 8'(led_sink_drive_o));
        rchk("opt1 all", ADDR_OPT1, 8'h23);
        wr(ADDR_OPT1, 8'h02);
        tick(2);
        chk("led pin 1", 8'h02, 8'(led_sink_drive_o));
        rchk("opt1 one", ADDR_OPT1, 8'h02);
    endtask : t_led

    // second reset after outputs were enabled: pins must fall back to inputs
    task automatic t_rerun;
        @(posedge sys_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        t_reset();
    endtask : t_rerun

    initial
    begin
        {resetn_i, wr_en_i, rd_en_i, addr_i, wr_data_i, ext_val, ext_en} = '0;
        {usb_function_on_i, usb_out_i, kbd_clock_gen_on_i, kbd_clk_low_i} = '0;
        {spi_pins_on_i, spi_out_i} = '0;
        usb_oe_n_i  = 2'b11;
        spi_oe_n_i  = 4'hf;
        ext_irq_n_i = 1'b1;
        repeat (16) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_port();
        t_pin2();
        t_irq();
        t_spi();
        t_led();
        t_rerun();
        end_of_test();
    end
endmodule : port_e_gpio_pin_mux_bench
